// *** rtl/dlb_consts.svh ***
/*
 * Constants for the divide and loop-branch execution block: opcodes,
 * flag bit positions and cycle counts.
 * Assumes it is included by bare name from rtl/ and nowhere redefined.
 */
`ifndef DLB_CONSTS_SVH
`define DLB_CONSTS_SVH

// opcode bytes as handed over by the decoder
`define DLB_OP_PREFIX        8'hf4
`define DLB_OP_DIV           8'hf8
`define DLB_OP_LOOP_A        8'hba
`define DLB_OP_LOOP_B        8'hca
`define DLB_OP_LOOP_FILE     8'hda

// status flag positions inside the 4-bit flag word
`define DLB_FLAG_C           3
`define DLB_FLAG_N           2
`define DLB_FLAG_Z           1
`define DLB_FLAG_V           0
`define DLB_FLAGS_OVERFLOW   4'hf

// machine cycle counts, one machine cycle per clk_i period
`define DLB_CYC_DIV_OVF      6'h0e
`define DLB_CYC_DIV_BASE     6'h37
`define DLB_CYC_DJ_ACC       6'h0a
`define DLB_CYC_DJ_FILE      6'h08
`define DLB_CYC_DJ_TAKEN     6'h02
`define DLB_CYC_NEVER        6'h3f

// divider step count and cycle counter width
`define DLB_DIV_STEPS        4'h8
`define DLB_CNT_W            6

`endif

// *** rtl/dlb_pkg.sv ***
/*
 * Types for the divide and loop-branch execution block.
 * Assumes dlb_consts.svh is on the include path.
 */
package dlb_pkg;

    typedef struct packed {
        logic        c;
        logic        n;
        logic        z;
        logic        v;
    } dlb_flags_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic        prefixed;
        logic [7:0]  acc_a;
        logic [7:0]  acc_b;
        logic [7:0]  file_register_operand;
        logic [7:0]  divisor_register;
        logic [7:0]  relative_offset_byte;
        logic [15:0] next_instr_address;
    } dlb_req_t;

    typedef struct packed {
        logic [7:0]  acc_a;
        logic [7:0]  acc_b;
        logic [7:0]  file_register_operand;
        logic [15:0] pc;
        dlb_flags_t  flags;
    } dlb_res_t;

    typedef enum logic [2:0] {
        DLB_K_NONE   = 3'h0,
        DLB_K_DIV    = 3'h1,
        DLB_K_DJ_A   = 3'h2,
        DLB_K_DJ_B   = 3'h3,
        DLB_K_DJ_F   = 3'h4
    } dlb_kind_t;

    // gray along idle -> divide -> hold only; hold -> idle flips both bits
    typedef enum logic [1:0] {
        DLB_S_IDLE   = 2'b00,
        DLB_S_DIVIDE = 2'b01,
        DLB_S_HOLD   = 2'b11
    } dlb_state_t;

endpackage

// *** rtl/dlb_divider.sv ***
/*
 * Restoring shift-subtract divider, 16 by 8 bits, one quotient bit per
 * clock. Assumes the caller has ruled out quotient overflow, so the
 * high dividend byte is below the divisor.
 */
`timescale 1ns/1ps
`include "dlb_consts.svh"

module dlb_divider (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [15:0] dividend_i,
    input  wire logic [7:0]  divisor_i,
    output logic             done_o,
    output logic [7:0]       quotient_o,
    output logic [7:0]       remainder_o
);

    logic [7:0] rem_q;
    logic [7:0] quo_q;
    logic [7:0] dvs_q;
    logic [3:0] step_q;
    logic       busy_q;
    logic       done_q;
    logic [8:0] trial;
    logic [8:0] diff;

    assign trial = {rem_q, quo_q[7]};
    assign diff  = trial - {1'b0, dvs_q};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rem_q  <= 8'h00;
            quo_q  <= 8'h00;
            dvs_q  <= 8'h00;
            step_q <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start_i) begin
                rem_q  <= dividend_i[15:8];
                quo_q  <= dividend_i[7:0];
                dvs_q  <= divisor_i;
                step_q <= 4'h0;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                // trial above 255 always exceeds an 8-bit divisor
                if (trial >= {1'b0, dvs_q}) begin
                    rem_q <= diff[7:0];
                    quo_q <= {quo_q[6:0], 1'b1};
                end else begin
                    rem_q <= trial[7:0];
                    quo_q <= {quo_q[6:0], 1'b0};
                end
                step_q <= step_q + 4'h1;
                if (step_q == `DLB_DIV_STEPS - 4'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign done_o      = done_q;
    assign quotient_o  = quo_q;
    assign remainder_o = rem_q;

endmodule

// *** rtl/dlb_exec.sv ***
/*
 * Execution unit for the 16/8 divide and the decrement-branch-nonzero
 * loop instruction of an 8-bit core.
 * Assumes the decoder presents a complete request with start_i for one
 * cycle, and that register file, program counter and status register
 * apply the write enables in the cycle done_o is high.
 */
`timescale 1ns/1ps
`include "dlb_consts.svh"

// How it works
// - divide accumulator pair A:B by divisor register
// - quotient into A, remainder into B
// - test quotient overflow before dividing
// - overflow aborts, operands kept, all flags set
// - overflow divide completes in 14 cycles
// - normal divide takes 55 to 63 cycles
// - decrement operand, branch relative if nonzero
// - decrement and branch fused in one instruction
// - loop branch never touches status flags
// - three loop opcodes, 10/12 and 8/10 cycles

module dlb_exec (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              start_i,
    input  wire dlb_pkg::dlb_req_t req_i,
    output logic                   ready_o,
    output logic                   busy_o,
    output logic                   done_o,
    output dlb_pkg::dlb_res_t      res_o,
    output logic                   wr_a_o,
    output logic                   wr_b_o,
    output logic                   wr_file_o,
    output logic                   wr_flags_o,
    output logic                   pc_load_o
);

    dlb_pkg::dlb_state_t       state_q;
    dlb_pkg::dlb_kind_t        kind;
    logic [`DLB_CNT_W-1:0]     cyc_q;
    logic [`DLB_CNT_W-1:0]     target_q;
    dlb_pkg::dlb_res_t         res_q;
    logic                      sel_a_q;
    logic                      sel_b_q;
    logic                      sel_file_q;
    logic                      sel_flags_q;
    logic                      sel_pc_q;
    logic                      accept;
    logic                      overflow;
    logic                      div_start;
    logic                      div_done;
    logic [7:0]                quotient;
    logic [7:0]                remainder;
    logic [7:0]                dj_operand;
    logic [7:0]                dj_value;
    logic                      dj_taken;
    logic [15:0]               dj_target;
    logic                      finish;

    function automatic dlb_pkg::dlb_kind_t decode_kind(
        input logic [7:0] op,
        input logic       prefixed
    );
        dlb_pkg::dlb_kind_t k;
        k = dlb_pkg::DLB_K_NONE;
        if (prefixed) begin
            if (op == `DLB_OP_DIV) begin
                k = dlb_pkg::DLB_K_DIV;
            end
        end else if (op == `DLB_OP_LOOP_A) begin
            k = dlb_pkg::DLB_K_DJ_A;
        end else if (op == `DLB_OP_LOOP_B) begin
            k = dlb_pkg::DLB_K_DJ_B;
        end else if (op == `DLB_OP_LOOP_FILE) begin
            k = dlb_pkg::DLB_K_DJ_F;
        end
        return k;
    endfunction

    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    assign kind   = decode_kind(req_i.opcode, req_i.prefixed);
    assign accept = start_i && (state_q == dlb_pkg::DLB_S_IDLE)
                    && (kind != dlb_pkg::DLB_K_NONE);

    // A at or above the divisor means the quotient cannot fit 8 bits;
    // a zero divisor lands here too, so no separate trap is needed
    assign overflow  = (req_i.acc_a >= req_i.divisor_register);
    assign div_start = accept && (kind == dlb_pkg::DLB_K_DIV) && !overflow;

    // one decrementer serves all three operand forms
    always_comb begin
        dj_operand = req_i.file_register_operand;
        if (kind == dlb_pkg::DLB_K_DJ_A) begin
            dj_operand = req_i.acc_a;
        end else if (kind == dlb_pkg::DLB_K_DJ_B) begin
            dj_operand = req_i.acc_b;
        end
    end

    assign dj_value  = dj_operand - 8'h01;
    assign dj_taken  = (dj_value != 8'h00);
    assign dj_target = req_i.next_instr_address
                       + {{8{req_i.relative_offset_byte[7]}},
                          req_i.relative_offset_byte};

    dlb_divider u_div (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .start_i     (div_start),
        .dividend_i  ({req_i.acc_a, req_i.acc_b}),
        .divisor_i   (req_i.divisor_register),
        .done_o      (div_done),
        .quotient_o  (quotient),
        .remainder_o (remainder)
    );

    assign finish = (state_q == dlb_pkg::DLB_S_HOLD)
                    && (cyc_q == target_q - `DLB_CNT_W'(1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= dlb_pkg::DLB_S_IDLE;
        end else begin
            case (state_q)
                dlb_pkg::DLB_S_IDLE: begin
                    if (div_start) begin
                        state_q <= dlb_pkg::DLB_S_DIVIDE;
                    end else if (accept) begin
                        state_q <= dlb_pkg::DLB_S_HOLD;
                    end
                end
                dlb_pkg::DLB_S_DIVIDE: begin
                    if (div_done) begin
                        state_q <= dlb_pkg::DLB_S_HOLD;
                    end
                end
                dlb_pkg::DLB_S_HOLD: begin
                    if (finish) begin
                        state_q <= dlb_pkg::DLB_S_IDLE;
                    end
                end
                default: begin
                    state_q <= dlb_pkg::DLB_S_IDLE;
                end
            endcase
        end
    end

    // cycle 0 is the start cycle; done lands in cycle target-1
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_q <= '0;
        end else if (accept) begin
            cyc_q <= `DLB_CNT_W'(1);
        end else if (state_q != dlb_pkg::DLB_S_IDLE) begin
            cyc_q <= cyc_q + `DLB_CNT_W'(1);
        end
    end

    // total length; a normal divide pays one cycle per quotient one bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            target_q <= `DLB_CYC_NEVER;
        end else if (accept) begin
            case (kind)
                dlb_pkg::DLB_K_DIV: begin
                    target_q <= overflow ? `DLB_CYC_DIV_OVF
                                         : `DLB_CYC_NEVER;
                end
                dlb_pkg::DLB_K_DJ_F: begin
                    target_q <= `DLB_CYC_DJ_FILE
                                + (dj_taken ? `DLB_CYC_DJ_TAKEN : 6'h00);
                end
                default: begin
                    target_q <= `DLB_CYC_DJ_ACC
                                + (dj_taken ? `DLB_CYC_DJ_TAKEN : 6'h00);
                end
            endcase
        end else if (div_done && state_q == dlb_pkg::DLB_S_DIVIDE) begin
            target_q <= `DLB_CYC_DIV_BASE
                        + {2'b00, count_ones(quotient)};
        end
    end

    // result word; untouched fields keep the incoming operands
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_q <= '0;
        end else if (accept) begin
            res_q.acc_a                 <= req_i.acc_a;
            res_q.acc_b                 <= req_i.acc_b;
            res_q.file_register_operand <= req_i.file_register_operand;
            res_q.pc                    <= req_i.next_instr_address;
            res_q.flags                 <= `DLB_FLAGS_OVERFLOW;
            if (kind == dlb_pkg::DLB_K_DJ_A) begin
                res_q.acc_a <= dj_value;
            end else if (kind == dlb_pkg::DLB_K_DJ_B) begin
                res_q.acc_b <= dj_value;
            end else if (kind == dlb_pkg::DLB_K_DJ_F) begin
                res_q.file_register_operand <= dj_value;
            end
            if (kind != dlb_pkg::DLB_K_DIV && dj_taken) begin
                res_q.pc <= dj_target;
            end
        end else if (div_done && state_q == dlb_pkg::DLB_S_DIVIDE) begin
            res_q.acc_a   <= quotient;
            res_q.acc_b   <= remainder;
            res_q.flags.c <= 1'b0;
            res_q.flags.v <= 1'b0;
            res_q.flags.n <= quotient[7];
            res_q.flags.z <= (quotient == 8'h00);
        end
    end

    // write selects, fixed at accept; both decrement and branch in one go
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_a_q     <= 1'b0;
            sel_b_q     <= 1'b0;
            sel_file_q  <= 1'b0;
            sel_flags_q <= 1'b0;
            sel_pc_q    <= 1'b0;
        end else if (accept) begin
            sel_a_q     <= (kind == dlb_pkg::DLB_K_DJ_A)
                           || div_start;
            sel_b_q     <= (kind == dlb_pkg::DLB_K_DJ_B) || div_start;
            sel_file_q  <= (kind == dlb_pkg::DLB_K_DJ_F);
            // loop forms never write the status register
            sel_flags_q <= (kind == dlb_pkg::DLB_K_DIV);
            // an overflowed divide leaves A, B and the divisor alone
            sel_pc_q    <= (kind != dlb_pkg::DLB_K_DIV) && dj_taken;
        end
    end

    assign ready_o    = (state_q == dlb_pkg::DLB_S_IDLE);
    assign busy_o     = (state_q != dlb_pkg::DLB_S_IDLE);
    assign done_o     = finish;
    assign res_o      = res_q;
    assign wr_a_o     = finish && sel_a_q;
    assign wr_b_o     = finish && sel_b_q;
    assign wr_file_o  = finish && sel_file_q;
    assign wr_flags_o = finish && sel_flags_q;
    assign pc_load_o  = finish && sel_pc_q;

endmodule

// *** dv/dlb_exec_sva.sv ***
/*
 * Checker for the divide and loop-branch execution unit.
 * Assumes it is bound to dlb_exec and sees only that module's ports.
 */
`timescale 1ns/1ps
`include "dlb_consts.svh"

module dlb_exec_sva (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              start_i,
    input  wire dlb_pkg::dlb_req_t req_i,
    input  wire logic              ready_o,
    input  wire logic              busy_o,
    input  wire logic              done_o,
    input  wire dlb_pkg::dlb_res_t res_o,
    input  wire logic              wr_a_o,
    input  wire logic              wr_b_o,
    input  wire logic              wr_file_o,
    input  wire logic              wr_flags_o,
    input  wire logic              pc_load_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic div_go;
    logic ovf_go;
    logic djf_go;
    logic dja_go;
    assign div_go = start_i && ready_o && req_i.prefixed
                    && req_i.opcode == `DLB_OP_DIV;
    assign ovf_go = div_go && req_i.acc_a >= req_i.divisor_register;
    assign djf_go = start_i && ready_o && !req_i.prefixed
                    && req_i.opcode == `DLB_OP_LOOP_FILE;
    assign dja_go = start_i && ready_o && !req_i.prefixed
                    && req_i.opcode == `DLB_OP_LOOP_A;

    AST_OVF_LEN: assert property (
        ovf_go |-> ##13 (done_o && res_o.flags == 4'hf))
        else $error("overflow divide length wrong");
    AST_OVF_KEEP: assert property (
        done_o && wr_flags_o && !wr_a_o |-> !wr_b_o && !wr_file_o
        && res_o.flags == `DLB_FLAGS_OVERFLOW)
        else $error("overflow divide wrote operands");
    AST_DIV_LEN: assert property (
        div_go && !ovf_go |-> ##[54:62] (done_o && wr_a_o && wr_b_o))
        else $error("divide length out of range");
    AST_DIV_FLAGS: assert property (
        done_o && wr_a_o && wr_b_o |-> !res_o.flags.c && !res_o.flags.v
        && res_o.flags.n == res_o.acc_a[7]
        && res_o.flags.z == (res_o.acc_a == 8'h00))
        else $error("divide flags wrong");
    AST_DJF_TAKEN: assert property (
        djf_go && req_i.file_register_operand != 8'h01
        |-> ##9 (done_o && pc_load_o && wr_file_o))
        else $error("file loop taken length wrong");
    AST_DJF_FALL: assert property (
        djf_go && req_i.file_register_operand == 8'h01
        |-> ##7 (done_o && !pc_load_o))
        else $error("file loop fall-through wrong");
    AST_DJA_TAKEN: assert property (
        dja_go && req_i.acc_a != 8'h01
        |-> ##11 (done_o && pc_load_o && wr_a_o))
        else $error("acc loop taken length wrong");
    AST_DJ_FLAGS: assert property (
        done_o && (wr_file_o || pc_load_o) |-> !wr_flags_o)
        else $error("loop wrote flags");
    AST_ONE_SHOT: assert property (
        done_o |=> !done_o && ready_o && !busy_o)
        else $error("done not a single pulse");

    COV_OVF: cover property (ovf_go);
    COV_DIV: cover property (div_go && !ovf_go);
    COV_DJF: cover property (djf_go);
endmodule

bind dlb_exec dlb_exec_sva dlb_exec_sva_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .req_i(req_i),
    .ready_o(ready_o), .busy_o(busy_o), .done_o(done_o), .res_o(res_o),
    .wr_a_o(wr_a_o), .wr_b_o(wr_b_o), .wr_file_o(wr_file_o),
    .wr_flags_o(wr_flags_o), .pc_load_o(pc_load_o)
);

// *** dv/test_divide_and_loop_branch_exec.sv ***
/*
 * Self-checking bench for the divide and loop-branch execution unit.
 * Assumes dlb_pkg and dlb_consts.svh are compiled and on the path.
 */
`timescale 1ns/1ps
`include "dlb_consts.svh"

module test_divide_and_loop_branch_exec;
    logic              clk_i;
    logic              rst_n_i;
    logic              start_i;
    dlb_pkg::dlb_req_t req_i;
    logic              ready_o;
    logic              busy_o;
    logic              done_o;
    dlb_pkg::dlb_res_t res_o;
    logic              wr_a_o, wr_b_o, wr_file_o, wr_flags_o, pc_load_o;
    int                errors;
    int                checked;

    dlb_exec dlb_exec_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .req_i(req_i),
        .ready_o(ready_o), .busy_o(busy_o), .done_o(done_o), .res_o(res_o),
        .wr_a_o(wr_a_o), .wr_b_o(wr_b_o), .wr_file_o(wr_file_o),
        .wr_flags_o(wr_flags_o), .pc_load_o(pc_load_o));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic dlb_pkg::dlb_req_t mk(input logic [7:0] op,
        input logic pre, input logic [7:0] a, b, f, d, off,
        input logic [15:0] nxt);
        mk = '{opcode:op, prefixed:pre, acc_a:a, acc_b:b,
               file_register_operand:f, divisor_register:d,
               relative_offset_byte:off, next_instr_address:nxt};
    endfunction

    // poke raises start again mid-instruction; it must be ignored
    task automatic run(input dlb_pkg::dlb_req_t r, input int poke,
        output int n, output dlb_pkg::dlb_res_t res, output logic [4:0] wr);
        n = 0;
        @(negedge clk_i);
        start_i = 1'b1;
        req_i = r;
        for (int k = 1; k < 80 && n == 0; k++) begin
            @(negedge clk_i);
            start_i = (k == poke);
            if (done_o === 1'b1) begin
                n = k + 1;
                res = res_o;
                wr = {wr_a_o, wr_b_o, wr_file_o, wr_flags_o, pc_load_o};
            end
        end
    endtask

    task automatic t_div(input logic [7:0] a, b, d);
        logic [15:0]       q;
        logic [15:0]       r;
        int                n;
        dlb_pkg::dlb_res_t res;
        logic [4:0]        wr;
        q = (d == 8'h00) ? 16'h0000 : {a, b} / {8'h00, d};
        r = (d == 8'h00) ? 16'h0000 : {a, b} % {8'h00, d};
        run(mk(`DLB_OP_DIV, 1'b1, a, b, 8'h33, d, 8'h00, 16'h0000), 0,
            n, res, wr);
        if (a >= d) begin
            chk(n, 14);
            chk({res.acc_a, res.acc_b}, {a, b});
            chk(res.flags, 4'hf);
            chk(wr, 5'b00010);
        end else begin
            chk(n, 55 + $countones(q[7:0]));
            chk({res.acc_a, res.acc_b}, {q[7:0], r[7:0]});
            chk(res.flags, {1'b0, q[7], q[7:0] == 8'h00, 1'b0});
            chk(wr, 5'b11010);
        end
    endtask

    task automatic t_loop(input logic [7:0] op, v, off,
        input logic [15:0] nxt, input int poke);
        logic              tk;
        logic              fa, fb, ff;
        int                n;
        dlb_pkg::dlb_res_t res;
        logic [4:0]        wr;
        fa = (op == `DLB_OP_LOOP_A);
        fb = (op == `DLB_OP_LOOP_B);
        ff = (op == `DLB_OP_LOOP_FILE);
        tk = (v != 8'h01);
        run(mk(op, 1'b0, fa ? v : 8'h5a, fb ? v : 8'ha5, ff ? v : 8'h3c,
               8'h07, off, nxt), poke, n, res, wr);
        chk(n, (ff ? 8 : 10) + (tk ? 2 : 0));
        chk(fa ? res.acc_a : fb ? res.acc_b : res.file_register_operand,
            8'(v - 8'h01));
        // sized casts keep the 8 and 16-bit wrap inside a 64-bit compare
        chk(res.pc, tk ? 16'(nxt + {{8{off[7]}}, off}) : nxt);
        chk(wr, {fa, fb, ff, 1'b0, tk});
    endtask

    task automatic t_bad;
        @(negedge clk_i);
        start_i = 1'b1;
        req_i = mk(`DLB_OP_DIV, 1'b0, 8'h00, 8'h10, 8'h00, 8'h02, 8'h00,
                   16'h0000);
        @(negedge clk_i);
        start_i = 1'b0;
        chk({ready_o, busy_o}, 2'b10);
        repeat (3) @(negedge clk_i);
        chk(done_o, 1'b0);
    endtask

    initial begin
        errors = 0;
        checked = 0;
        rst_n_i = 1'b0;
        start_i = 1'b0;
        req_i = '0;
        repeat (6) @(negedge clk_i);
        chk({ready_o, busy_o, done_o, wr_flags_o}, 4'b1000);
        rst_n_i = 1'b1;
        t_div(8'h12, 8'h34, 8'h56);
        t_div(8'h00, 8'h00, 8'h01);
        t_div(8'hfe, 8'hff, 8'hff);
        t_div(8'h10, 8'h00, 8'h10);
        t_div(8'h00, 8'h05, 8'h00);
        t_loop(`DLB_OP_LOOP_A, 8'h01, 8'h05, 16'h0010, 0);
        t_loop(`DLB_OP_LOOP_A, 8'h00, 8'hfe, 16'h0010, 3);
        t_loop(`DLB_OP_LOOP_B, 8'h80, 8'h02, 16'hfffe, 0);
        t_loop(`DLB_OP_LOOP_B, 8'h01, 8'h80, 16'h2000, 4);
        t_loop(`DLB_OP_LOOP_FILE, 8'h02, 8'h80, 16'h0100, 5);
        t_loop(`DLB_OP_LOOP_FILE, 8'h01, 8'h7f, 16'h0100, 0);
        t_bad;
        summarize;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #(25 * 4000);
        errors++;
        summarize;
    end
endmodule
